// ===== logic/ubrg_cfg.svh
// Constants of the serial bit-rate generator: offsets, fields, reset values
`ifndef UBRG_CFG_SVH
`define UBRG_CFG_SVH
// ==========================================
// Register byte offsets
`define UBRG_OFS_DIVISOR 8'h00
`define UBRG_OFS_CTRL_ONE 8'h04
`define UBRG_OFS_CTRL_TWO 8'h08
`define UBRG_OFS_STATUS 8'h0C
`define UBRG_OFS_TX_DATA 8'h10
`define UBRG_OFS_RX_DATA 8'h14
// ==========================================
// Field positions of serial_control_one
`define UBRG_C1_BASE_SEL 0
`define UBRG_C1_PARITY_EN 1
`define UBRG_C1_EVEN 2
`define UBRG_C1_STOP_LEN 3
`define UBRG_C1_TX_EN 4
`define UBRG_C1_RX_EN 5
// ==========================================
// Field positions of the status register
`define UBRG_ST_TX_BUSY 0
`define UBRG_ST_RX_BUSY 1
`define UBRG_ST_RX_FULL 2
`define UBRG_ST_PAR_ERR 3
`define UBRG_ST_FRM_ERR 4
// ==========================================
// Reset values and fixed counts
`define UBRG_RST_DIVISOR 8'h00
`define UBRG_RST_CTRL_ONE 6'h00
`define UBRG_RST_RT_SEL 3'h0
`define UBRG_SAMPLE_HI 5'h08
`define UBRG_SAMPLE_LO 5'h06
// Tick counter load values (ticks per bit minus one)
`define UBRG_LOAD_T15 5'h0E
`define UBRG_LOAD_T16 5'h0F
`define UBRG_LOAD_T17 5'h10
`define UBRG_RESP_OKAY 2'h0
`define UBRG_RESP_SLVERR 2'h2
`endif

// ===== logic/ubrg_pkg.sv
// Types of the serial bit-rate generator
package ubrg_pkg;
	// Ticks-per-bit selector codes
	typedef enum logic [2:0] {
		UBRG_RT16 = 3'h0,
		UBRG_RT16_17 = 3'h1,
		UBRG_RT15 = 3'h2,
		UBRG_RT15_16 = 3'h3,
		UBRG_RT17 = 3'h4
	} ubrg_rtsel_e;
	// Receiver states
	typedef enum logic [0:0] {
		UBRG_RX_IDLE,
		UBRG_RX_FRAME
	} ubrg_rx_e;
endpackage : ubrg_pkg

// ===== logic/ubrg_top.sv
// Serial transceiver with programmable bit-rate generator and AXI4-Lite registers
// Notes on behaviour
// - Bit rate from base clock, divisor, tick select
// - One tick per divisor plus one base clocks
// - Ticks per bit programmable from 15 to 17
// - Codes 000/010/100 give 16/15/17 ticks
// - Codes 001/011 alternate, start bit shorter
// - Bit rate is base clock over ticks times divisor+1
// - Transmit and receive share ticks per bit
// - Low-frequency clock may drive the prescaler
// - Frame: start, eight data, parity, stop bits
// - Receiver majority-samples ticks eight to six
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ubrg_cfg.svh"
module ubrg_top
	import ubrg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_low_freq_clock,
	input wire logic i_serial_input_pin,
	output logic o_serial_output,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Tick count minus one for a bit, given selector and bit parity
	function automatic logic [4:0] rt_load(input logic [2:0] sel, input logic odd);
		case (sel)
			UBRG_RT16: rt_load = `UBRG_LOAD_T16;
			UBRG_RT15: rt_load = `UBRG_LOAD_T15;
			UBRG_RT17: rt_load = `UBRG_LOAD_T17;
			UBRG_RT16_17: rt_load = odd ? `UBRG_LOAD_T17 : `UBRG_LOAD_T16;
			UBRG_RT15_16: rt_load = odd ? `UBRG_LOAD_T16 : `UBRG_LOAD_T15;
			default: rt_load = `UBRG_LOAD_T16;
		endcase
	endfunction : rt_load
	// ==========================================
	// Registers
	logic [7:0] baud_divisor, rx_data;
	logic [5:0] serial_control_one;
	logic [2:0] rt_count_select;
	logic rx_full, par_err, frm_err, lf_prev, rx_prev;
	wire base_clock_select = serial_control_one[`UBRG_C1_BASE_SEL];
	wire parity_enable = serial_control_one[`UBRG_C1_PARITY_EN];
	wire even_parity = serial_control_one[`UBRG_C1_EVEN];
	wire stop_length_select = serial_control_one[`UBRG_C1_STOP_LEN];
	// Base clock event: every gear cycle or each rising low-frequency edge
	wire base_evt = base_clock_select ? (i_low_freq_clock & ~lf_prev) : 1'b1;
	// ==========================================
	// AXI4-Lite slave
	logic aw_hold, w_hold, w_lane0, tx_busy, rx_busy, rx_done;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire wr_go = aw_hold & w_hold & ~s_axi_bvalid;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire wr_div = wr_go & w_lane0 & (aw_addr_q == `UBRG_OFS_DIVISOR);
	wire wr_c1 = wr_go & w_lane0 & (aw_addr_q == `UBRG_OFS_CTRL_ONE);
	wire wr_c2 = wr_go & w_lane0 & (aw_addr_q == `UBRG_OFS_CTRL_TWO);
	wire wr_tx = wr_go & w_lane0 & (aw_addr_q == `UBRG_OFS_TX_DATA);
	wire wr_ok = aw_addr_q <= `UBRG_OFS_RX_DATA && aw_addr_q[1:0] == 2'h0;
	wire rd_rx = ar_hs & (s_axi_araddr == `UBRG_OFS_RX_DATA);
	wire [31:0] status_word = {27'h0, frm_err, par_err, rx_full, rx_busy, tx_busy};
	wire rd_ok = s_axi_araddr <= `UBRG_OFS_RX_DATA && s_axi_araddr[1:0] == 2'h0;
	// Read data selection
	wire [31:0] rd_mux =
		(s_axi_araddr == `UBRG_OFS_DIVISOR) ? {24'h0, baud_divisor} :
		(s_axi_araddr == `UBRG_OFS_CTRL_ONE) ? {26'h0, serial_control_one} :
		(s_axi_araddr == `UBRG_OFS_CTRL_TWO) ? {29'h0, rt_count_select} :
		(s_axi_araddr == `UBRG_OFS_STATUS) ? status_word :
		(s_axi_araddr == `UBRG_OFS_RX_DATA) ? {24'h0, rx_data} : 32'h0;
	// Address and data capture, write response
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UBRG_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Read response
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `UBRG_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// Setting registers; receive-full flag where a new frame beats a read
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			baud_divisor <= `UBRG_RST_DIVISOR;
			serial_control_one <= `UBRG_RST_CTRL_ONE;
			rt_count_select <= `UBRG_RST_RT_SEL;
			lf_prev <= 1'b0;
			rx_full <= 1'b0;
		end else begin
			lf_prev <= i_low_freq_clock;
			if (wr_div)
				baud_divisor <= w_data_q[7:0];
			if (wr_c1)
				serial_control_one <= w_data_q[5:0];
			if (wr_c2)
				rt_count_select <= w_data_q[2:0];
			rx_full <= rx_done | (rx_full & ~rd_rx); // A completing frame beats the read
		end
	end
	// ==========================================
	// Transmitter
	logic [7:0] tx_pre;
	logic [4:0] tx_rt;
	logic [3:0] tx_idx;
	logic [11:0] tx_shift;
	wire tx_tick = tx_busy & base_evt & (tx_pre == baud_divisor);
	wire tx_bit_end = tx_tick & (tx_rt == 5'h00);
	wire [3:0] tx_last = 4'h9 + {3'h0, parity_enable} + {3'h0, stop_length_select};
	wire tx_start = wr_tx & ~tx_busy & serial_control_one[`UBRG_C1_TX_EN];
	wire tx_par = even_parity ? ^w_data_q[7:0] : ~^w_data_q[7:0];
	// Frame image sent LSB first: start, data, parity or stop, stops
	wire [11:0] tx_frame = parity_enable ? {2'h3, tx_par, w_data_q[7:0], 1'b0}
		: {3'h7, w_data_q[7:0], 1'b0};
	// Prescaler, tick counter and shifter
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tx_busy <= 1'b0;
			tx_pre <= 8'h00;
			tx_rt <= 5'h00;
			tx_idx <= 4'h0;
			tx_shift <= 12'hFFF;
		end else if (tx_start) begin
			tx_busy <= 1'b1;
			tx_pre <= 8'h00;
			tx_rt <= rt_load(rt_count_select, 1'b0);
			tx_idx <= 4'h0;
			tx_shift <= tx_frame;
		end else if (tx_busy) begin
			if (base_evt)
				tx_pre <= tx_tick ? 8'h00 : tx_pre + 8'h01;
			if (tx_bit_end) begin
				tx_rt <= rt_load(rt_count_select, ~tx_idx[0]);
				tx_idx <= tx_idx + 4'h1;
				tx_shift <= {1'b1, tx_shift[11:1]};
				tx_busy <= (tx_idx != tx_last);
			end else if (tx_tick) begin
				tx_rt <= tx_rt - 5'h01;
			end
		end
	end
	assign o_serial_output = tx_shift[0];
	// ==========================================
	// Receiver
	ubrg_rx_e rx_state;
	logic [7:0] rx_pre;
	logic [4:0] rx_rt;
	logic [3:0] rx_idx;
	logic [2:0] rx_samp;
	logic [9:0] rx_shift;
	assign rx_busy = (rx_state == UBRG_RX_FRAME);
	wire rx_tick = rx_busy & base_evt & (rx_pre == baud_divisor);
	wire rx_bit_end = rx_tick & (rx_rt == 5'h00);
	wire rx_fall = rx_prev & ~i_serial_input_pin;
	wire rx_in_win = rx_rt <= `UBRG_SAMPLE_HI && rx_rt >= `UBRG_SAMPLE_LO;
	wire rx_bit = (rx_samp[0] & (rx_samp[1] | rx_samp[2])) | (rx_samp[1] & rx_samp[2]);
	wire [3:0] rx_last = 4'h9 + {3'h0, parity_enable};
	assign rx_done = rx_bit_end & (rx_idx == rx_last);
	wire [9:0] rx_img = {rx_bit, rx_shift[9:1]};
	// Stop sits on top; data lies under the parity bit, or under the stop bit alone
	wire [7:0] rx_word = parity_enable ? rx_img[7:0] : rx_img[8:1];
	// Receive frame sequencer
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rx_state <= UBRG_RX_IDLE;
			rx_prev <= 1'b1;
			rx_pre <= 8'h00;
			rx_rt <= 5'h00;
			rx_idx <= 4'h0;
			rx_samp <= 3'h0;
			rx_shift <= 10'h000;
			rx_data <= 8'h00;
			par_err <= 1'b0;
			frm_err <= 1'b0;
		end else begin
			rx_prev <= i_serial_input_pin;
			case (rx_state)
				UBRG_RX_IDLE: begin
					if (rx_fall & serial_control_one[`UBRG_C1_RX_EN]) begin
						rx_state <= UBRG_RX_FRAME;
						rx_pre <= 8'h00;
						rx_rt <= rt_load(rt_count_select, 1'b0);
						rx_idx <= 4'h0;
					end
				end
				UBRG_RX_FRAME: begin
					if (base_evt)
						rx_pre <= rx_tick ? 8'h00 : rx_pre + 8'h01;
					if (rx_tick & rx_in_win)
						rx_samp <= {rx_samp[1:0], i_serial_input_pin};
					if (rx_bit_end) begin
						rx_rt <= rt_load(rt_count_select, ~rx_idx[0]);
						rx_idx <= rx_idx + 4'h1;
						rx_shift <= rx_img;
						if (rx_idx == 4'h0 && rx_bit)
							rx_state <= UBRG_RX_IDLE;
						if (rx_done) begin
							rx_state <= UBRG_RX_IDLE;
							rx_data <= rx_word;
							par_err <= parity_enable & (rx_img[8] ^ ^rx_img[7:0] ^ ~even_parity);
							frm_err <= ~rx_bit;
						end
					end else if (rx_tick) begin
						rx_rt <= rx_rt - 5'h01;
					end
				end
				default: rx_state <= UBRG_RX_IDLE;
			endcase
		end
	end
	// ==========================================
	// Checks
	logic [4:0] tx_cnt, rx_cnt;
	logic [8:0] tx_gap;
	// Ticks seen in the current bit, clocks since the last transmit tick
	always_ff @(posedge i_clk) begin
		tx_cnt <= (i_srst | tx_start | tx_bit_end) ? 5'h00 : tx_cnt + {4'h0, tx_tick};
		tx_gap <= (i_srst | tx_start | tx_tick) ? 9'h000 : tx_gap + 9'h001;
		rx_cnt <= (i_srst | ~rx_busy | rx_bit_end) ? 5'h00 : rx_cnt + {4'h0, rx_tick};
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	a_tick_gear_spacing: assert property (
		tx_tick && !base_clock_select && $stable(baud_divisor) && tx_idx != 4'h0
		|-> tx_gap == {1'b0, baud_divisor}) else $error("tick spacing wrong");
	a_tx_bit_ticks: assert property (
		tx_bit_end |-> tx_cnt == rt_load(rt_count_select, tx_idx[0])) else $error("tx bit length");
	a_alt_start_short: assert property (
		tx_start && rt_count_select == UBRG_RT16_17 |=> tx_rt == 5'h0F) else $error("alt phase");
	a_rt_range: assert property (
		tx_rt <= 5'h10 && rx_rt <= 5'h10) else $error("tick counter out of range");
	a_rx_bit_ticks: assert property (
		rx_bit_end |-> rx_cnt == rt_load(rt_count_select, rx_idx[0])) else $error("rx bit length");
	a_start_bit_low: assert property (
		tx_start |=> !o_serial_output [*2]) else $error("start bit not low");
	a_idle_line_high: assert property (
		!tx_busy |-> o_serial_output) else $error("idle line low");
	a_rx_start_edge: assert property (
		!rx_busy && rx_fall && serial_control_one[`UBRG_C1_RX_EN] |=> rx_busy && rx_idx == 4'h0)
		else $error("receiver missed start edge");
	a_rx_full_set: assert property (
		rx_done |=> rx_full) else $error("receive flag not set");
endmodule : ubrg_top

// ===== sim/ubrg_peer.sv
// Remote serial transceiver model driving the receive line
`timescale 1ns/10ps
module ubrg_peer (
	input wire logic i_clk,
	output logic o_line
);
	// Line idles high between frames
	initial o_line = 1'b1;
	// Ticks in bit i of a frame for a selector code
	function automatic int ticks(input logic [2:0] sel, input int i);
		case (sel)
			3'h1: return (i % 2) ? 17 : 16;
			3'h2: return 15;
			3'h3: return (i % 2) ? 16 : 15;
			3'h4: return 17;
			default: return 16;
		endcase
	endfunction : ticks
	// Level of bit i: start, data LSB first, parity, stop
	function automatic logic lvl(input logic [7:0] d, input int i, input logic pe, ev);
		if (i == 0) return 1'b0;
		if (i < 9) return d[i-1];
		if (i == 9 && pe) return ev ? ^d : ~^d;
		return 1'b1;
	endfunction : lvl
	// Sends one frame at the exact nominal rate, so no rate error
	task automatic send(input logic [7:0] d, input logic [2:0] sel, input int dv, sc,
		input logic pe, ev);
		for (int i = 0; i < 10 + pe; i++) begin
			o_line <= lvl(d, i, pe, ev);
			repeat (ticks(sel, i) * (dv + 1) * sc) @(posedge i_clk);
		end
	endtask : send
endmodule : ubrg_peer

// ===== sim/testbench.sv
// Self-checking bench of the serial bit-rate generator
`timescale 1ns/10ps
`include "ubrg_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic i_clk, i_srst, lf, rxl, txl;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, dv, d;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic awready, wready, bvalid, arready, rvalid, pe, ev, base, st;
	logic [1:0] bresp, rresp, rd_r, wr_r;
	logic [2:0] sel;
	logic [15:0] rnd = 16'h0010;
	int n_fail = 0, cmp_count = 0, cyc = 0;
	// ==========================================
	// Design and remote model
	ubrg_top i_ubrg_top (.i_clk(i_clk), .i_srst(i_srst), .i_low_freq_clock(lf),
		.i_serial_input_pin(rxl), .o_serial_output(txl), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	ubrg_peer i_ubrg_peer (.i_clk(i_clk), .o_line(rxl));
	// ==========================================
	// Clocks: 25 MHz main, low-frequency base at eight main periods
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	initial begin
		lf = 1'b0;
		#7;
		forever #160 lf = ~lf;
	end
	// Hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Register write; ready flags settle by the falling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge i_clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			wr_r = bresp;
			@(posedge i_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
	endtask : wr
	// Register read into rd_v and rd_r
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge i_clk);
			ta = arvalid & arready;
			tr = rvalid;
			rd_v = rdata;
			rd_r = rresp;
			@(posedge i_clk);
			if (ta) arvalid <= 1'b0;
		end
	endtask : rd
	// Samples each transmitted bit in its middle
	task automatic tx_chk(input int sc);
		int len;
		for (int t = 0; t < 50 && txl !== 1'b0; t++) @(negedge i_clk);
		for (int i = 0; i < 10 + pe + st; i++) begin
			len = i_ubrg_peer.ticks(sel, i) * (dv + 1) * sc;
			repeat (len / 2) @(posedge i_clk);
			@(negedge i_clk);
			`CHK(txl, i_ubrg_peer.lvl(d, i, pe, ev))
			repeat (len - len / 2) @(posedge i_clk);
		end
	endtask : tx_chk
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// ==========================================
	// Main sequence
	initial begin
		i_srst = 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		for (int a = 0; a < 12; a += 4) begin
			rd(8'(a));
			`CHK(rd_v, 32'h0)
		end
		rd(8'h18);
		`CHK(rd_r, `UBRG_RESP_SLVERR)
		wr(8'h18, 32'h0);
		`CHK(wr_r, `UBRG_RESP_SLVERR)
		for (int k = 0; k < 7; k++) begin
			rnd = lfsr(rnd);
			sel = (k < 5) ? 3'(k) : 3'(rnd % 5);
			base = (k == 5);
			dv = base ? 8'h00 : {6'h0, rnd[9:8]};
			d = rnd[7:0];
			pe = rnd[10];
			ev = rnd[11];
			st = rnd[12];
			wr(`UBRG_OFS_DIVISOR, {24'h0, dv});
			wr(`UBRG_OFS_CTRL_ONE, {26'h0, 2'b11, st, ev, pe, base});
			wr(`UBRG_OFS_CTRL_TWO, {29'h0, sel});
			`CHK(wr_r, `UBRG_RESP_OKAY)
			rd(`UBRG_OFS_CTRL_TWO);
			`CHK(rd_v, {29'h0, sel})
			wr(`UBRG_OFS_TX_DATA, {24'h0, d});
			tx_chk(base ? 8 : 1);
			i_ubrg_peer.send(~d, sel, dv, base ? 8 : 1, pe, ev);
			// Receiver finishes a clock behind the remote model
			repeat (2) @(posedge i_clk);
			rd(`UBRG_OFS_STATUS);
			`CHK(rd_v, 32'h1 << `UBRG_ST_RX_FULL)
			rd(`UBRG_OFS_RX_DATA);
			`CHK(rd_v[7:0], ~d)
			$display("test %0d done", k);
		end
		summarize();
	end
endmodule : testbench
